// File: hdl/daoc_top.sv
// Top of the dual converter output control block with its register slave
`timescale 1ns/1ps
module daoc_top
  import daoc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Channel control pins
  input wire logic chan_a_sample_clock,
  input wire logic chan_b_sample_clock,
  input wire logic bus_steer_select,
  input wire logic chan_a_power_down_select,
  input wire logic chan_b_power_down_select,
  input wire logic chan_a_output_enable_n,
  input wire logic chan_b_output_enable_n,
  // Quantizer codes, two's complement
  input wire logic [13:0] chan_a_code,
  input wire logic [13:0] chan_b_code,
  // Output bus A
  output logic [11:0] bus_a_result_word,
  output logic bus_a_range_flag,
  output logic bus_a_drive_n,
  // Output bus B
  output logic [11:0] bus_b_result_word,
  output logic bus_b_range_flag,
  output logic bus_b_drive_n,
  // Status
  output logic stabilizer_on,
  output logic irq
);
  logic rst_s1_r;
  logic rst_n_r;
  logic [1:0] clk_s1_r, clk_s2_r, clk_s3_r;
  logic [1:0] pd_s1_r, pd_s2_r;
  logic [1:0] oen_s1_r, oen_s2_r;
  logic steer_s1_r, steer_s2_r;
  logic [13:0] code_s1_r [DAOC_CH];
  logic [13:0] code_s2_r [DAOC_CH];
  logic [13:0] code_pin [DAOC_CH];
  logic [1:0] mode_r;
  logic [3:0] irq_st_r;
  logic [3:0] irq_mask_r;
  logic [3:0] irq_nxt;
  logic [3:0] mask_nxt;
  logic fmt_tc;
  logic [1:0] edge_c;
  logic [1:0] shift;
  logic [1:0] asleep;
  logic [1:0] dval;
  logic [1:0] dstb;
  logic [1:0] dval_d_r;
  logic [1:0] drive;
  daoc_pwr_e pwr [DAOC_CH];
  daoc_sample_s conv [DAOC_CH];
  daoc_sample_s res [DAOC_CH];
  daoc_sample_s last_r [DAOC_CH];
  logic wb_req;
  logic wb_wr;
  logic [31:0] rd_data;

  assign code_pin[0] = chan_a_code;
  assign code_pin[1] = chan_b_code;

  // ****************************************************************
  // Reset release
  // ****************************************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      clk_s1_r <= 2'h0;
      clk_s2_r <= 2'h0;
      clk_s3_r <= 2'h0;
      pd_s1_r <= 2'h3;
      pd_s2_r <= 2'h3;
      oen_s1_r <= 2'h3;
      oen_s2_r <= 2'h3;
      steer_s1_r <= 1'b1;
      steer_s2_r <= 1'b1;
    end else begin
      clk_s1_r <= {chan_b_sample_clock, chan_a_sample_clock};
      clk_s2_r <= clk_s1_r;
      clk_s3_r <= clk_s2_r;
      pd_s1_r <= {chan_b_power_down_select, chan_a_power_down_select};
      pd_s2_r <= pd_s1_r;
      oen_s1_r <= {chan_b_output_enable_n, chan_a_output_enable_n};
      oen_s2_r <= oen_s1_r;
      steer_s1_r <= bus_steer_select;
      steer_s2_r <= steer_s1_r;
    end
  end

  // ****************************************************************
  // Per-channel conversion path
  // ****************************************************************
  genvar c;
  generate
    for (c = 0; c < DAOC_CH; c++) begin : g_ch
      logic signed [13:0] code;

      always_ff @(posedge mclk or negedge rst_n_r) begin
        if (!rst_n_r) begin
          code_s1_r[c] <= 14'h0000;
          code_s2_r[c] <= 14'h0000;
        end else begin
          code_s1_r[c] <= code_pin[c];
          code_s2_r[c] <= code_s1_r[c];
        end
      end

      always_comb begin
        unique case ({pd_s2_r[c], oen_s2_r[c]})
          2'b00: pwr[c] = DAOC_NORMAL;
          2'b01: pwr[c] = DAOC_HIZ;
          2'b10: pwr[c] = DAOC_NAP;
          2'b11: pwr[c] = DAOC_SLEEP;
        endcase
      end

      assign code = code_s2_r[c];
      assign edge_c[c] = clk_s2_r[c] && !clk_s3_r[c];
      assign asleep[c] = pd_s2_r[c];
      assign shift[c] = edge_c[c] && !asleep[c];

      always_comb begin
        conv[c].ovr = (code > DAOC_CODE_MAX) || (code < DAOC_CODE_MIN);
        if (code > DAOC_CODE_MAX) begin
          conv[c].word = 12'h7ff;
        end else if (code < DAOC_CODE_MIN) begin
          conv[c].word = 12'h800;
        end else begin
          conv[c].word = code[11:0];
        end
        if (!fmt_tc) begin
          conv[c].word[DAOC_W-1] = ~conv[c].word[DAOC_W-1];
        end
      end

      daoc_pipe u_pipe (
        .clk(mclk),
        .rst_n(rst_n_r),
        .shift(shift[c]),
        .flush(asleep[c]),
        .din(conv[c]),
        .dout(res[c]),
        .dval(dval[c]),
        .dstb(dstb[c])
      );

      assign drive[c] = (pwr[c] == DAOC_NORMAL) && dval[c];

      always_ff @(posedge mclk or negedge rst_n_r) begin
        if (!rst_n_r) begin
          last_r[c] <= '0;
        end else if (dstb[c]) begin
          last_r[c] <= res[c];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  assign fmt_tc = (mode_r == DAOC_MODE_TWO_THIRD) || (mode_r == DAOC_MODE_FULL);

  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      stabilizer_on <= 1'b0;
    end else begin
      stabilizer_on <= (mode_r == DAOC_MODE_THIRD) || (mode_r == DAOC_MODE_TWO_THIRD);
    end
  end

  // ****************************************************************
  // Bus steering
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      bus_a_result_word <= 12'h000;
      bus_a_range_flag <= 1'b0;
      bus_a_drive_n <= 1'b1;
      bus_b_result_word <= 12'h000;
      bus_b_range_flag <= 1'b0;
      bus_b_drive_n <= 1'b1;
    end else if (steer_s2_r) begin
      bus_a_result_word <= res[0].word;
      bus_a_range_flag <= res[0].ovr;
      bus_a_drive_n <= !drive[0];
      bus_b_result_word <= res[1].word;
      bus_b_range_flag <= res[1].ovr;
      bus_b_drive_n <= !drive[1];
    end else begin
      bus_a_result_word <= res[1].word;
      bus_a_range_flag <= res[1].ovr;
      bus_a_drive_n <= !drive[1];
      bus_b_result_word <= res[0].word;
      bus_b_range_flag <= res[0].ovr;
      bus_b_drive_n <= !drive[0];
    end
  end

  // ****************************************************************
  // Wishbone slave
  // ****************************************************************
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Writes land at the edge that shows the acknowledge to the master
  assign wb_wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];

  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (wb_adr_i)
      DAOC_OFS_CTRL: rd_data[DAOC_CTRL_MODE_LSB +: 2] = mode_r;
      DAOC_OFS_STAT: begin
        rd_data[3:0] = pwr[0];
        rd_data[DAOC_STAT_PWR_B_LSB +: 4] = pwr[1];
        rd_data[DAOC_STAT_STEER] = steer_s2_r;
        rd_data[DAOC_STAT_TC] = fmt_tc;
        rd_data[DAOC_STAT_DCS] = stabilizer_on;
      end
      DAOC_OFS_IRQ: rd_data[3:0] = irq_st_r;
      DAOC_OFS_MASK: rd_data[3:0] = irq_mask_r;
      DAOC_OFS_RES_A: rd_data[DAOC_RES_FLAG:0] = last_r[0];
      DAOC_OFS_RES_B: rd_data[DAOC_RES_FLAG:0] = last_r[1];
      default: rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_data : 32'h0000_0000;
    end
  end

  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      mode_r <= DAOC_CTRL_RST;
    end else if (wb_wr && wb_adr_i == DAOC_OFS_CTRL) begin
      mode_r <= wb_dat_i[DAOC_CTRL_MODE_LSB +: 2];
    end
  end

  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      irq_mask_r <= DAOC_MASK_RST;
    end else if (wb_wr && wb_adr_i == DAOC_OFS_MASK) begin
      irq_mask_r <= wb_dat_i[3:0];
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  assign mask_nxt = (wb_wr && wb_adr_i == DAOC_OFS_MASK) ? wb_dat_i[3:0] : irq_mask_r;

  always_comb begin
    irq_nxt = irq_st_r;
    if (wb_wr && wb_adr_i == DAOC_OFS_IRQ) begin
      irq_nxt = irq_nxt & ~wb_dat_i[3:0];
    end
    // Events set last, so they win over a clear in the same cycle
    irq_nxt[DAOC_IRQ_OVR_LSB +: 2] = irq_nxt[DAOC_IRQ_OVR_LSB +: 2] | (dstb & {res[1].ovr, res[0].ovr});
    irq_nxt[DAOC_IRQ_RDY_LSB +: 2] = irq_nxt[DAOC_IRQ_RDY_LSB +: 2] | (dval & ~dval_d_r);
  end

  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      irq_st_r <= DAOC_IRQ_RST;
      dval_d_r <= 2'h0;
      irq <= 1'b0;
    end else begin
      irq_st_r <= irq_nxt;
      dval_d_r <= dval;
      irq <= |(irq_nxt & mask_nxt);
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n_r);

  edge_start_a: assert property (
    shift[0] |-> clk_s2_r[0] && !$past(clk_s2_r[0]) && !pd_s2_r[0])
    else $error("sample taken without a rising channel clock");
  steer_high_a: assert property (
    steer_s2_r && drive[0] |=> !bus_a_drive_n && bus_a_result_word == $past(res[0].word))
    else $error("bus A does not carry channel A");
  steer_low_a: assert property (
    !steer_s2_r && drive[0] |=> !bus_b_drive_n && bus_b_range_flag == $past(res[0].ovr))
    else $error("bus B does not carry channel A when swapped");
  normal_drive_a: assert property (
    steer_s2_r && !pd_s2_r[1] && !oen_s2_r[1] && dval[1] |=> !bus_b_drive_n)
    else $error("normal channel not driving");
  hiz_state_a: assert property (
    steer_s2_r && pwr[0] == DAOC_HIZ |=> bus_a_drive_n)
    else $error("disabled outputs still driven");
  nap_state_a: assert property (
    !steer_s2_r && pwr[0] == DAOC_NAP |=> bus_b_drive_n)
    else $error("nap channel still drives");
  sleep_state_a: assert property (
    pwr[1] == DAOC_SLEEP && steer_s2_r |=> bus_b_drive_n && !dval[1])
    else $error("sleeping channel drives");
  mode_dcs_a: assert property (
    mode_r == DAOC_MODE_FULL [*2] |-> !stabilizer_on && fmt_tc)
    else $error("full mode decodes wrongly");
  range_flag_a: assert property (
    dstb[0] && res[0].ovr |=> irq_st_r[DAOC_IRQ_OVR_LSB])
    else $error("range event lost");
  msb_format_a: assert property (
    !conv[0].ovr && !fmt_tc |-> conv[0].word[11] == !code_s2_r[0][13])
    else $error("offset binary MSB wrong");
  wake_hold_a: assert property (
    $fell(pd_s2_r[0]) |-> !dval[0] [*5])
    else $error("data valid too soon after wake");
  irq_level_a: assert property (
    irq == |(irq_st_r & irq_mask_r))
    else $error("interrupt not raised");

  steer_swap_c: cover property ($changed(steer_s2_r) && drive[0]);
  wake_up_c: cover property ($rose(dval[1]));
  ovr_irq_c: cover property ($rose(irq));
endmodule // daoc_top

// File: hdl/daoc_pkg.sv
// Package of constants and types for the dual converter output control block
// ****************************************************************************
// ****************************************************************************
package daoc_pkg;
  localparam int DAOC_CH = 2;
  localparam int DAOC_W = 12;
  localparam int DAOC_CODE_W = 14;
  localparam int DAOC_LAT = 5;
  localparam logic [2:0] DAOC_LAT_CNT = 3'h5;
  localparam logic signed [13:0] DAOC_CODE_MAX = 14'sh07ff;
  localparam logic signed [13:0] DAOC_CODE_MIN = 14'sh3800;
  // Register byte offsets
  localparam logic [7:0] DAOC_OFS_CTRL = 8'h00;
  localparam logic [7:0] DAOC_OFS_STAT = 8'h04;
  localparam logic [7:0] DAOC_OFS_IRQ = 8'h08;
  localparam logic [7:0] DAOC_OFS_MASK = 8'h0c;
  localparam logic [7:0] DAOC_OFS_RES_A = 8'h10;
  localparam logic [7:0] DAOC_OFS_RES_B = 8'h14;
  // Field positions
  localparam int DAOC_CTRL_MODE_LSB = 0;
  localparam int DAOC_IRQ_OVR_LSB = 0;
  localparam int DAOC_IRQ_RDY_LSB = 2;
  localparam int DAOC_STAT_PWR_B_LSB = 4;
  localparam int DAOC_STAT_STEER = 8;
  localparam int DAOC_STAT_TC = 9;
  localparam int DAOC_STAT_DCS = 10;
  localparam int DAOC_RES_FLAG = 12;
  // Reset values
  localparam logic [1:0] DAOC_CTRL_RST = 2'h0;
  localparam logic [3:0] DAOC_IRQ_RST = 4'h0;
  localparam logic [3:0] DAOC_MASK_RST = 4'h0;
  // Four-level mode select
  localparam logic [1:0] DAOC_MODE_GND = 2'h0;
  localparam logic [1:0] DAOC_MODE_THIRD = 2'h1;
  localparam logic [1:0] DAOC_MODE_TWO_THIRD = 2'h2;
  localparam logic [1:0] DAOC_MODE_FULL = 2'h3;

  typedef enum logic [3:0] {
    DAOC_NORMAL = 4'b0001,
    DAOC_HIZ = 4'b0010,
    DAOC_NAP = 4'b0100,
    DAOC_SLEEP = 4'b1000
  } daoc_pwr_e;

  typedef struct packed {
    logic ovr;
    logic [11:0] word;
  } daoc_sample_s;
endpackage

// File: hdl/daoc_pipe.sv
// Six-stage conversion pipeline of one channel
`timescale 1ns/1ps
module daoc_pipe
  import daoc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic shift,
  input wire logic flush,
  // Data
  input daoc_sample_s din,
  output daoc_sample_s dout,
  output logic dval,
  output logic dstb
);
  // Capture stage plus five latency stages
  daoc_sample_s stage_r [DAOC_LAT+1];
  logic [DAOC_LAT:0] vld_r;
  logic [2:0] fill_r;

  // ****************************************************************
  // Stages
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g <= DAOC_LAT; g++) begin : g_stage
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          stage_r[g] <= '0;
          vld_r[g] <= 1'b0;
        end else if (flush) begin
          vld_r[g] <= 1'b0;
        end else if (shift) begin
          stage_r[g] <= (g == 0) ? din : stage_r[(g == 0) ? 0 : g - 1];
          vld_r[g] <= (g == 0) ? 1'b1 : vld_r[(g == 0) ? 0 : g - 1];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dstb <= 1'b0;
    end else begin
      // Marks every new valid word, the first one after a refill too
      dstb <= shift && !flush && vld_r[DAOC_LAT-1];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fill_r <= 3'h0;
    end else if (flush) begin
      fill_r <= 3'h0;
    end else if (shift && vld_r[0] && fill_r != DAOC_LAT_CNT) begin
      fill_r <= fill_r + 3'h1;
    end
  end

  assign dout = stage_r[DAOC_LAT];
  assign dval = vld_r[DAOC_LAT];

  // ****************************************************************
  // Checks
  // ****************************************************************
  pipe_fill_a: assert property (@(posedge clk) disable iff (!rst_n)
    dval == (fill_r == DAOC_LAT_CNT)) else $error("output valid before five samples");
  pipe_flush_a: assert property (@(posedge clk) disable iff (!rst_n)
    flush |=> !dval [*5]) else $error("valid data seen after flush");
endmodule // daoc_pipe

// File: verification/daoc_capture.sv
// Downstream capture model that shares one bus between both channels
`timescale 1ns/1ps
module daoc_capture
  import daoc_pkg::*;
(
  // Clock and control
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic hold_b,
  // Buses from the block
  input daoc_sample_s bus_a,
  input daoc_sample_s bus_b,
  input wire logic [1:0] drive_n,
  // Sample clocks and steer
  output logic clk_a,
  output logic clk_b,
  output logic steer,
  output logic [4:0] ph,
  // Captured words
  output logic cap_stb,
  output daoc_sample_s cap_a,
  output daoc_sample_s cap_b,
  output logic [1:0] cap_off
);
  // **********
  // Shared clock and capture
  // **********
  logic seen_r;
  // Steer and the channel A clock are one wire
  assign clk_a = steer;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ph <= 5'h18;
      steer <= 1'b0;
      clk_b <= 1'b0;
      seen_r <= 1'b0;
      cap_stb <= 1'b0;
      cap_a <= '0;
      cap_b <= '0;
      cap_off <= 2'h3;
    end else begin
      cap_stb <= 1'b0;
      if (run) begin
        ph <= ph + 5'h1;
        // Take both buses at the end of each clock phase
        if (ph == 5'h0f || ph == 5'h1f) begin
          cap_stb <= seen_r;
          cap_a <= bus_a;
          cap_b <= bus_b;
          cap_off <= drive_n;
        end
        if (ph == 5'h0f) begin
          steer <= 1'b0;
          clk_b <= 1'b0;
        end
        if (ph == 5'h1f) begin
          steer <= 1'b1;
          clk_b <= ~hold_b;
          seen_r <= 1'b1;
        end
      end
    end
  end
endmodule // daoc_capture

// File: verification/daoc_top_tb.sv
// Self-checking bench of the dual converter output control block
`timescale 1ns/1ps
module daoc_top_tb
  import daoc_pkg::*;
;
  // **********
  // Signals
  // **********
  typedef struct packed {
    logic [1:0] off;
    daoc_sample_s a;
    daoc_sample_s b;
  } daoc_exp_s;
  logic mclk, arst_n, wb_cyc, wb_stb, wb_we, wb_ack_o;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat, wb_dat_o;
  logic pd_a, pd_b, oe_n_a, oe_n_b, drv_a_n, drv_b_n, stab, irq;
  logic [13:0] code_a, code_b;
  daoc_sample_s bus_a, bus_b, cap_a, cap_b;
  logic run, hold_b, clk_a, clk_b, steer, cap_stb;
  logic [4:0] ph;
  logic [1:0] cap_off, mode, ov_seen;
  logic [1:0] st[2];
  daoc_exp_s exp_q[$];
  daoc_exp_s e_mon;
  daoc_sample_s hist[2][128];
  int n[2];
  int vf[2];
  int mismatches, num_checks, cyc;

  daoc_top daoc_top_inst (
    .mclk(mclk), .arst_n(arst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .chan_a_sample_clock(clk_a), .chan_b_sample_clock(clk_b),
    .bus_steer_select(steer), .chan_a_power_down_select(pd_a),
    .chan_b_power_down_select(pd_b), .chan_a_output_enable_n(oe_n_a),
    .chan_b_output_enable_n(oe_n_b), .chan_a_code(code_a), .chan_b_code(code_b),
    .bus_a_result_word(bus_a.word), .bus_a_range_flag(bus_a.ovr), .bus_a_drive_n(drv_a_n),
    .bus_b_result_word(bus_b.word), .bus_b_range_flag(bus_b.ovr), .bus_b_drive_n(drv_b_n),
    .stabilizer_on(stab), .irq(irq)
  );
  daoc_capture daoc_capture_inst (
    .mclk(mclk), .rst_n(arst_n), .run(run), .hold_b(hold_b), .bus_a(bus_a), .bus_b(bus_b),
    .drive_n({drv_b_n, drv_a_n}), .clk_a(clk_a), .clk_b(clk_b), .steer(steer), .ph(ph),
    .cap_stb(cap_stb), .cap_a(cap_a), .cap_b(cap_b), .cap_off(cap_off)
  );

  always #25 mclk = ~mclk;

  // **********
  // Tasks
  // **********
  task automatic stop_test;
    if (mismatches == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d, output logic [31:0] q);
    int t;
    t = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_sel <= s;
    wb_dat <= d;
    do begin
      @(posedge mclk);
      t++;
    end while (wb_ack_o !== 1'b1);
    chk(t < 16, 1'b1);
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge mclk);
  endtask

  // Expected bus word of one code; out-of-range codes clamp and flag
  function automatic daoc_sample_s conv(input logic [13:0] c, input logic [1:0] m);
    daoc_sample_s s;
    s.ovr = ($signed(c) > DAOC_CODE_MAX) || ($signed(c) < DAOC_CODE_MIN);
    s.word = ($signed(c) > DAOC_CODE_MAX) ? 12'h7ff :
             ($signed(c) < DAOC_CODE_MIN) ? 12'h800 : c[11:0];
    if (m < 2'h2)
      s.word[11] = ~s.word[11];
    return s;
  endfunction

  function automatic logic [13:0] rnd_code;
    logic [31:0] r;
    r = $urandom;
    return (r[2:0] == 3'h0) ? r[31:18] : {{2{r[31]}}, r[31:20]};
  endfunction

  // Two captures per period: steer high, then steer low with buses swapped
  task automatic push_exp(input logic keep);
    logic [1:0] ok;
    daoc_sample_s s[2];
    daoc_exp_s e;
    for (int c = 0; c < 2; c++) begin
      ok[c] = (st[c] == 2'h0) && (n[c] - 6 >= vf[c]);
      s[c] = ok[c] ? hist[c][n[c] - 6] : '0;
      // A converting channel flags range events with its outputs off too
      if (n[c] - 6 >= vf[c] && hist[c][n[c] - 6].ovr)
        ov_seen[c] = 1'b1;
    end
    if (keep) begin
      e = {~ok, s[0], s[1]};
      exp_q.push_back(e);
      e = {~ok[0], ~ok[1], s[1], s[0]};
      exp_q.push_back(e);
    end
  endtask

  task automatic sample_next(input logic hold);
    logic [13:0] c[2];
    c[0] = rnd_code();
    c[1] = rnd_code();
    code_a <= c[0];
    code_b <= c[1];
    for (int k = 0; k < 2; k++) begin
      if (k == 0 || !hold) begin
        hist[k][n[k]] = conv(c[k], mode);
        n[k]++;
      end
      // Nap or sleep discards everything taken so far
      if (st[k][1])
        vf[k] = n[k];
    end
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      stop_test();
    end
  end

  always @(posedge mclk) begin
    if (cap_stb === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk(32'h1, 32'h0);
      end else begin
        e_mon = exp_q.pop_front();
        chk(cap_off, e_mon.off);
        if (!e_mon.off[0]) chk(cap_a, e_mon.a);
        if (!e_mon.off[1]) chk(cap_b, e_mon.b);
      end
    end
  end

  // **********
  // Sequence
  // **********
  initial begin
    logic [31:0] q;
    logic [7:0] adr[5];
    logic [31:0] rv[5];
    logic hold, chg;
    logic [1:0] m;
    mclk = 1'b0;
    arst_n = 1'b0;
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat} = '0;
    {pd_a, pd_b, oe_n_a, oe_n_b, code_a, code_b, run, hold_b} = '0;
    {mismatches, num_checks, cyc} = '0;
    {n[0], n[1], vf[0], vf[1], st[0], st[1], mode, ov_seen} = '0;
    adr = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h20};
    rv = '{32'h0, 32'h11, 32'h0, 32'h0, 32'h0};
    void'($urandom(32'h8cb13511));
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    wb(1'b1, DAOC_OFS_CTRL, 4'he, 32'h3, q);
    for (int i = 0; i < 5; i++) begin
      wb(1'b0, adr[i], 4'hf, 32'h0, q);
      chk(q, rv[i]);
    end
    sample_next(1'b0);
    run <= 1'b1;
    for (int p = 0; p < 52; p++) begin
      @(posedge mclk iff ph == 5'h07);
      case (p)
        6: st[0] = 2'h1;
        8: st[0] = 2'h0;
        12: st[0] = 2'h2;
        15: st[0] = 2'h0;
        22: st[1] = 2'h3;
        25: st[1] = 2'h0;
        36: st[1] = 2'h2;
        37: st[1] = 2'h0;
        44: st[0] = 2'h3;
        50: st[1] = 2'h1;
        default: ;
      endcase
      hold = (p >= 28 && p < 33);
      m = (p >= 36) ? 2'h3 : 2'(p / 12);
      chg = (m != mode);
      mode = m;
      {pd_a, oe_n_a, pd_b, oe_n_b} <= {st[0], st[1]};
      hold_b <= hold;
      push_exp(1'b1);
      sample_next(hold);
      if (chg) begin
        wb(1'b1, DAOC_OFS_CTRL, 4'h1, {30'h0, m}, q);
        @(posedge mclk);
        chk(stab, m == 2'h1 || m == 2'h2);
      end
    end
    @(posedge mclk iff ph == 5'h07);
    run <= 1'b0;
    // The last channel clock edge still shifts one word out
    push_exp(1'b0);
    repeat (8) @(posedge mclk);
    wb(1'b0, DAOC_OFS_STAT, 4'hf, 32'h0, q);
    chk(q[10:0], {mode == 2'h1 || mode == 2'h2, mode[1], 1'b1, 4'h1 << st[1],
                  4'h1 << st[0]});
    wb(1'b0, DAOC_OFS_RES_B, 4'hf, 32'h0, q);
    chk(q, {19'h0, hist[1][n[1] - 6]});
    wb(1'b0, DAOC_OFS_IRQ, 4'hf, 32'h0, q);
    chk(q[1:0], ov_seen);
    chk(irq, 1'b0);
    wb(1'b1, DAOC_OFS_MASK, 4'h1, 32'h3, q);
    repeat (2) @(posedge mclk);
    chk(irq, |ov_seen);
    wb(1'b1, DAOC_OFS_IRQ, 4'h1, 32'hf, q);
    repeat (2) @(posedge mclk);
    chk(irq, 1'b0);
    wb(1'b0, DAOC_OFS_IRQ, 4'hf, 32'h0, q);
    chk(q, 32'h0);
    chk(exp_q.size(), 32'h0);
    stop_test();
  end
endmodule // daoc_top_tb
